/* File: rtl/itoirq_pkg.sv */
// constants for the interval timer with overflow request
package itoirq_pkg;
   // ----------------------------------------------------------------
   // register indexes (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_MODE = 16'hFFA6;
   localparam logic [15:0] IDX_COUNT = 16'hFFA7;
   localparam logic [15:0] IDX_ENABLE = 16'hFFF4;
   localparam logic [15:0] IDX_REQUEST = 16'hFFF6;
   // ----------------------------------------------------------------
   // fields and values
   // ----------------------------------------------------------------
   localparam int OVF_BIT = 6;
   localparam logic [7:0] MODE_INTERVAL_DIV4096 = 8'h11;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam int PRESCALE_WIDTH = 13;
   localparam int DIV_LOG2 = 12;
   localparam logic [DIV_LOG2-1:0] TAP_LAST = 12'hFFF;
   localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 13'h0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* File: rtl/itoirq_top.sv */
// interval timer with overflow request flag behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module itoirq_top (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output var logic [31:0] hrdata,
   output var logic hreadyout,
   output var logic hresp,
   input wire logic cpuIrqMask,
   output var logic requestPending,
   output var logic timerIrq
);
   import itoirq_pkg::*;

   // ----------------------------------------------------------------
   // bus address phase capture
   // ----------------------------------------------------------------
   logic wrPend_reg;
   logic [15:0] wrIdx_reg;
   logic [7:0] mode_reg;
   logic [7:0] count_reg;
   logic [7:0] enable_reg;
   logic flag_reg;
   logic [PRESCALE_WIDTH-1:0] prescale_reg;
   logic [7:0] modeNext;
   logic [7:0] countNext;
   logic [7:0] enableNext;
   logic flagNext;
   logic [31:0] rdataNext;

   // one index compare shared by the write strobes and the read mux
   function automatic logic hitReg(input logic [15:0] idx, input logic [15:0] target);
      return idx == target;
   endfunction

   // hsize is not checked: only whole-word singles are issued
   wire addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
   wire rdAddr = addrPhase & ~hwrite;
   wire [15:0] accIdx = haddr[17:2];
   wire wrMode = wrPend_reg & hitReg(wrIdx_reg, IDX_MODE);
   wire wrEnable = wrPend_reg & hitReg(wrIdx_reg, IDX_ENABLE);
   wire wrRequest = wrPend_reg & hitReg(wrIdx_reg, IDX_REQUEST);

   // remember the write target until its data phase
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wrPend_reg <= 1'b0;
         wrIdx_reg <= 16'h0000;
      end else begin
         wrPend_reg <= addrPhase & hwrite;
         wrIdx_reg <= accIdx;
      end
   end

   // ----------------------------------------------------------------
   // prescaler and count
   // ----------------------------------------------------------------
   // tap fires once every 4096 clocks, on the last state of the low 12 bits
   wire tapTick = (prescale_reg[DIV_LOG2-1:0] == TAP_LAST);
   // other mode codes leave the count frozen; only interval /4096 is built
   wire modeRun = (mode_reg == MODE_INTERVAL_DIV4096);
   wire countStep = tapTick & modeRun;
   wire overflow = countStep & (count_reg == COUNT_MAX);

   // count has no write path at all
   assign countNext = countStep ? count_reg + 8'h01 : count_reg;
   assign modeNext = wrMode ? hwdata[7:0] : mode_reg;
   assign enableNext = wrEnable ? hwdata[7:0] : enable_reg;
   // set beats a same-cycle software clear; writing 1 leaves it alone
   assign flagNext = overflow | (flag_reg & ~(wrRequest & ~hwdata[OVF_BIT]));

   // free-running prescaler
   always_ff @(posedge core_clk) begin
      if (srst) begin
         prescale_reg <= PRESCALE_RESET;
      end else begin
         prescale_reg <= prescale_reg + 13'h0001;
      end
   end

   // timer and software registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mode_reg <= MODE_RESET;
         count_reg <= COUNT_RESET;
         enable_reg <= ENABLE_RESET;
         flag_reg <= 1'b0;
      end else begin
         mode_reg <= modeNext;
         count_reg <= countNext;
         enable_reg <= enableNext;
         flag_reg <= flagNext;
      end
   end

   // ----------------------------------------------------------------
   // read data and request outputs
   // ----------------------------------------------------------------
   // read from the next values so a read right after a write sees it
   assign rdataNext = hitReg(accIdx, IDX_MODE) ? {24'h000000, modeNext} :
                      hitReg(accIdx, IDX_COUNT) ? {24'h000000, countNext} :
                      hitReg(accIdx, IDX_ENABLE) ? {24'h000000, enableNext} :
                      hitReg(accIdx, IDX_REQUEST) ? {24'h000000, 1'b0, flagNext, 6'h00} :
                      32'h00000000;

   // zero-wait slave, always OKAY; unmapped reads give zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hrdata <= rdAddr ? rdataNext : 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // outputs follow the next state so they line up with the flag
   always_ff @(posedge core_clk) begin
      if (srst) begin
         requestPending <= 1'b0;
         timerIrq <= 1'b0;
      end else begin
         requestPending <= flagNext;
         timerIrq <= flagNext & enableNext[OVF_BIT] & ~cpuIrqMask;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_pending_flag: assert property (@(posedge core_clk) disable iff (srst)
      requestPending == flag_reg)
      else $error("pending output differs from flag");

   a_enable_gate: assert property (@(posedge core_clk) disable iff (srst)
      !enable_reg[OVF_BIT] |-> !timerIrq)
      else $error("request passed with enable clear");

   a_mode_stop: assert property (@(posedge core_clk) disable iff (srst)
      (mode_reg != MODE_INTERVAL_DIV4096) |=> $stable(count_reg))
      else $error("count moved outside interval mode");

   a_count_step: assert property (@(posedge core_clk) disable iff (srst)
      countStep |=> count_reg == $past(count_reg) + 8'h01)
      else $error("count did not step on tap");

   a_count_hold: assert property (@(posedge core_clk) disable iff (srst)
      !tapTick |=> $stable(count_reg))
      else $error("count moved without tap");

   // flag and pending output rise together; a clear one cycle later is legal
   a_ovf_sets: assert property (@(posedge core_clk) disable iff (srst)
      overflow |=> flag_reg && requestPending)
      else $error("overflow did not set flag");

   a_flag_clear: assert property (@(posedge core_clk) disable iff (srst)
      (wrRequest && !hwdata[OVF_BIT] && !overflow) |=> !flag_reg)
      else $error("flag clear lost");

   a_flag_source: assert property (@(posedge core_clk) disable iff (srst)
      $rose(flag_reg) |-> $past(overflow))
      else $error("flag set without overflow");

   a_flag_hold: assert property (@(posedge core_clk) disable iff (srst)
      (flag_reg && !wrRequest) |=> flag_reg)
      else $error("flag dropped without a clear");

   a_tap_period: assert property (@(posedge core_clk) disable iff (srst)
      tapTick |=> !tapTick [*8])
      else $error("tap too frequent");

   a_irq_cond: assert property (@(posedge core_clk) disable iff (srst)
      timerIrq |-> flag_reg && enable_reg[OVF_BIT] && !$past(cpuIrqMask))
      else $error("irq without all conditions");

   a_irq_fires: assert property (@(posedge core_clk) disable iff (srst)
      (flag_reg && enable_reg[OVF_BIT] && !$past(cpuIrqMask)) |-> timerIrq)
      else $error("irq missing with all conditions");

   a_count_wrap: assert property (@(posedge core_clk) disable iff (srst)
      overflow |=> count_reg == COUNT_RESET)
      else $error("count did not wrap");

   a_count_ro: assert property (@(posedge core_clk) disable iff (srst)
      (wrPend_reg && (wrIdx_reg == IDX_COUNT) && !countStep) |=> $stable(count_reg))
      else $error("count changed by a write");

   // ----------------------------------------------------------------
   // bus and prescaler assertions
   // ----------------------------------------------------------------
   a_bus_okay: assert property (@(posedge core_clk) disable iff (srst)
      hreadyout && !hresp)
      else $error("bus not ready or not okay");

   a_rdata_idle: assert property (@(posedge core_clk) disable iff (srst)
      !$past(rdAddr) |-> hrdata == 32'h00000000)
      else $error("read data outside read data phase");

   a_rdata_upper: assert property (@(posedge core_clk) disable iff (srst)
      hrdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");

   // first edge after reset has no valid previous value, so it is skipped
   a_prescale_step: assert property (@(posedge core_clk) disable iff (srst)
      !$past(srst) |-> prescale_reg == $past(prescale_reg) + 13'h0001)
      else $error("prescaler did not step");

   // ----------------------------------------------------------------
   // cover points
   // ----------------------------------------------------------------
   c_overflow: cover property (@(posedge core_clk) disable iff (srst) overflow);
   c_irq: cover property (@(posedge core_clk) disable iff (srst) $rose(timerIrq));
   c_set_clear: cover property (@(posedge core_clk) disable iff (srst) overflow && wrRequest);
   c_count_step: cover property (@(posedge core_clk) disable iff (srst) countStep);
   c_mode_freeze: cover property (@(posedge core_clk) disable iff (srst) tapTick && !modeRun);
endmodule
`default_nettype wire

/* File: sim/test_interval_timer_overflow_irq.sv */
// self-checking bench for the interval timer registers and counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failCount++; $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module test_interval_timer_overflow_irq;
   import itoirq_pkg::*;
   logic core_clk, srst, hsel, hwrite, cpuIrqMask;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, requestPending, timerIrq;
   int failCount = 0;
   int comparisons = 0;
   int cyc = 0;
   // single slave, so its ready output is the bus ready
   itoirq_top uut (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cpuIrqMask(cpuIrqMask), .requestPending(requestPending),
      .timerIrq(timerIrq));
   // 50 ns clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // cycles since reset release; the ceiling cuts a hang short
   always @(posedge core_clk) begin
      if (!srst) cyc++;
      if (cyc == 40000) begin
         failCount++;
         printVerdict();
      end
   end
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   // address phase, then data phase; hsel stays up so no double drive at one step
   task automatic xfer(input logic isWr, input logic [15:0] idx, input logic [7:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= isWr;
      haddr <= {14'h0000, idx, 2'h0};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, idx, d, q);
   endtask
   task automatic rdChk(input logic [15:0] idx, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, idx, 8'h00, q);
      `CHK(q, e)
   endtask
   task automatic untilCyc(input int n);
      while (cyc < n) @(posedge core_clk);
   endtask
   task automatic printVerdict();
      $display("comparisons %0d, mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // reads placed mid-way between taps so a cycle of bus latency cannot matter
   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      cpuIrqMask = 1'b1;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      `CHK({hreadyout, hresp, requestPending, timerIrq}, 4'h8)
      rdChk(IDX_MODE, 32'h00000000);
      rdChk(IDX_REQUEST, 32'h00000000);
      $display("test reset values done");
      wr(IDX_ENABLE, 8'h40);
      rdChk(IDX_ENABLE, 32'h00000040);
      wr(IDX_REQUEST, 8'hFF);
      rdChk(IDX_REQUEST, 32'h00000000);
      cpuIrqMask <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK({requestPending, timerIrq}, 2'h0)
      $display("test enable and request done");
      wr(IDX_MODE, MODE_INTERVAL_DIV4096);
      rdChk(IDX_MODE, 32'h00000011);
      wr(IDX_COUNT, 8'h55);
      rdChk(IDX_COUNT, 32'h00000000);
      rdChk(16'h0001, 32'h00000000);
      $display("test mode and read-only count done");
      untilCyc(6144);
      rdChk(IDX_COUNT, 32'h00000001);
      untilCyc(10240);
      rdChk(IDX_COUNT, 32'h00000002);
      wr(IDX_MODE, 8'h10);
      untilCyc(18432);
      rdChk(IDX_COUNT, 32'h00000002);
      wr(IDX_MODE, MODE_INTERVAL_DIV4096);
      untilCyc(22528);
      rdChk(IDX_COUNT, 32'h00000003);
      $display("test counting done");
      printVerdict();
   end
endmodule
`default_nettype wire
